// >>> design/rbtc_pkg.sv
// constants, states and carriers of the reset, boot and test control block
// assumes a single core clock; every pin input is synchronised in the top module
`default_nettype none
package rbtc_pkg;
  // ==========================================================================
  // timing and sizing
  localparam int unsigned ROM_CLK_DIV = 256;
  localparam int unsigned ROM_DIV_W = 8;
  localparam logic [7:0] ROM_DIV_LAST = 8'hff;
  localparam logic [7:0] ROM_SAMPLE_AT = 8'h7f;
  localparam int unsigned TIMEOUT_PULSE = 256;
  localparam int unsigned PULSE_W = 9;
  localparam logic [8:0] TIMEOUT_PULSE_LOAD = 9'h100;
  localparam int unsigned TIMEOUT_DEFAULT = 1000000000;
  localparam int unsigned BOOT_BITS_DEFAULT = 64;
  localparam int unsigned IRQ_LINES = 6;
  localparam int unsigned SYNC_STAGES = 2;
  // ==========================================================================
  // values after reset
  localparam logic STATUS_RST = 1'b0;
  localparam logic ROM_OE_N_RST = 1'b1;
  localparam logic [1:0] SYNC_RST = 2'h0;
  // ==========================================================================
  // sequencer states and carriers
  typedef enum logic [1:0] {S_HOLD, S_BIST, S_BOOT, S_RUN} rbtc_state_t;
  typedef struct packed {
    logic done;
    logic pass;
  } rbtc_bist_t;
  typedef struct packed {
    logic valid;
    logic data;
  } rbtc_rom_bit_t;
endpackage
`default_nettype wire

// >>> design/rbtc_top.sv
// reset sequencing, serial boot rom read, self-test status and timeout pulse,
// clock source select, wake capture and interrupt synchronisation
// assumes the board keeps nrst low until supply_good is high and that the
// cache self-test engine and retire signal run on the same core clock
//
// Behaviour
// - reset release after supply good starts the internal reset sequence.
// - boot rom clock period is 256 core clock periods.
// - each boot rom clock cycle the rom presents a bit which we sample.
// - drive boot rom output enable low while the rom is read.
// - test status is low during system reset.
// - test status goes high when cache self-test starts.
// - self-test pass drives status low; failure leaves it high.
// - raise timeout reset when nothing retires for one billion cycles.
// - timeout drives one 256 cycle high pulse on test status.
// - bypass select switches internal clocking to the input clock pair.
// - wake request is captured on the core clock when a synchronised framing clock rise is seen.
// - six interrupt lines are passed on for software to handle.
`default_nettype none
module rbtc_top
  import rbtc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = rbtc_pkg::TIMEOUT_DEFAULT,
  parameter int unsigned BOOT_BITS = rbtc_pkg::BOOT_BITS_DEFAULT
)(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic supply_good,
  input wire logic boot_rom_din,
  output logic boot_rom_clk,
  output logic boot_rom_clk_oe,
  output logic boot_rom_oe_n,
  output logic boot_rom_oe_n_oe,
  output rbtc_pkg::rbtc_rom_bit_t boot_bit,
  output logic boot_done,
  output logic bist_start,
  input wire rbtc_pkg::rbtc_bist_t bist_result,
  input wire logic instr_retired,
  output logic timeout_reset,
  output logic selftest_status,
  output logic selftest_status_oe,
  output logic core_run,
  input wire logic loop_bypass_sel,
  input wire logic [1:0] input_clock_pair,
  output logic clock_src_bypass,
  output logic bypass_clk_level,
  input wire logic framing_clock,
  input wire logic wake_request,
  output logic wake_captured,
  input wire logic [rbtc_pkg::IRQ_LINES-1:0] irq_in,
  output logic [rbtc_pkg::IRQ_LINES-1:0] irq_out
);
  import rbtc_pkg::*;

  localparam int unsigned TO_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);
  localparam int unsigned BB_W = $clog2(BOOT_BITS + 1);
  localparam logic [BB_W-1:0] BB_LAST = BB_W'(BOOT_BITS - 1);

  // refuse sizes the counters cannot serve
  initial
  begin
    if (TIMEOUT_CYCLES < 2 || BOOT_BITS < 1)
    begin
      $error("rbtc_top: TIMEOUT_CYCLES must be >= 2 and BOOT_BITS >= 1");
    end
  end

  // rising edge seen between two successive samples
  function automatic logic rbtc_rise(input logic cur, input logic prev);
    rbtc_rise = cur & ~prev;
  endfunction

  // ==========================================================================
  // input synchronisers
  localparam int unsigned NSYNC = IRQ_LINES + 7;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] next_sync_a;
  logic [NSYNC-1:0] next_sync_b;
  logic [SYNC_STAGES-1:0] rst_sync;
  logic [SYNC_STAGES-1:0] next_rst_sync;
  logic frame_prev;
  logic next_frame_prev;

  // pin inputs: two flops each, first flop read only by the second
  always_comb
  begin
    next_sync_a = {irq_in, supply_good, boot_rom_din, loop_bypass_sel,
                   input_clock_pair, framing_clock, wake_request};
    next_sync_b = sync_a;
    next_rst_sync = {rst_sync[0], 1'b1};
    next_frame_prev = sync_b[1];
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_a <= '0;
      sync_b <= '0;
      rst_sync <= SYNC_RST;
      frame_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      rst_sync <= next_rst_sync;
      frame_prev <= next_frame_prev;
    end
  end

  logic wake_s;
  logic frame_s;
  logic pair_h_s;
  logic pair_l_s;
  logic bypass_s;
  logic rom_din_s;
  logic supply_s;
  logic rst_active;
  logic frame_rise;
  assign wake_s = sync_b[0];
  assign frame_s = sync_b[1];
  assign pair_l_s = sync_b[2];
  assign pair_h_s = sync_b[3];
  assign bypass_s = sync_b[4];
  assign rom_din_s = sync_b[5];
  assign supply_s = sync_b[6];
  assign rst_active = ~rst_sync[SYNC_STAGES-1];
  assign frame_rise = rbtc_rise(frame_s, frame_prev);

  // ==========================================================================
  // reset sequencer and boot rom reader
  rbtc_state_t state;
  rbtc_state_t next_state;
  logic [ROM_DIV_W-1:0] rom_div;
  logic [ROM_DIV_W-1:0] next_rom_div;
  logic [BB_W-1:0] bit_cnt;
  logic [BB_W-1:0] next_bit_cnt;
  rbtc_rom_bit_t next_boot_bit;
  logic next_boot_rom_clk;
  logic next_boot_rom_oe_n;
  logic next_bist_start;
  logic next_boot_done;
  logic bits_all;
  logic next_bits_all;

  // hold, then self-test, then boot rom read, then run
  always_comb
  begin
    next_state = state;
    next_rom_div = rom_div;
    next_bit_cnt = bit_cnt;
    next_bits_all = bits_all;
    next_boot_bit = '0;
    next_bist_start = 1'b0;
    next_boot_done = boot_done;
    case (state)
      S_HOLD:
      begin
        next_rom_div = '0;
        next_bit_cnt = '0;
        next_bits_all = 1'b0;
        next_boot_done = 1'b0;
        if (!rst_active && supply_s)
        begin
          next_state = S_BIST;
          next_bist_start = 1'b1;
        end
      end
      S_BIST:
      begin
        if (bist_result.done)
        begin
          next_state = S_BOOT;
        end
      end
      S_BOOT:
      begin
        next_rom_div = rom_div + 8'h01;
        if (rom_div == ROM_SAMPLE_AT && !bits_all)
        begin
          next_boot_bit.valid = 1'b1;
          next_boot_bit.data = rom_din_s;
          next_bit_cnt = bit_cnt + BB_W'(1);
          next_bits_all = (bit_cnt == BB_LAST);
        end
        if (rom_div == ROM_DIV_LAST && bits_all)
        begin
          next_state = S_RUN;
          next_boot_done = 1'b1;
        end
      end
      S_RUN:
      begin
        next_rom_div = '0;
      end
      default:
      begin
        next_state = S_HOLD;
      end
    endcase
    if (rst_active)
    begin
      next_state = S_HOLD;
    end
    next_boot_rom_clk = (next_state == S_BOOT) ? next_rom_div[ROM_DIV_W-1] : 1'b1;
    next_boot_rom_oe_n = (next_state == S_BOOT) ? 1'b0 : 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= S_HOLD;
      rom_div <= '0;
      bit_cnt <= '0;
      bits_all <= 1'b0;
      boot_bit <= '0;
      boot_rom_clk <= 1'b1;
      boot_rom_oe_n <= ROM_OE_N_RST;
      bist_start <= 1'b0;
      boot_done <= 1'b0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      rom_div <= next_rom_div;
      bit_cnt <= next_bit_cnt;
      bits_all <= next_bits_all;
      boot_bit <= next_boot_bit;
      boot_rom_clk <= next_boot_rom_clk;
      boot_rom_oe_n <= next_boot_rom_oe_n;
      bist_start <= next_bist_start;
      boot_done <= next_boot_done;
    end
  end

  // open drain pins: drive only while pulling low
  assign boot_rom_clk_oe = ~boot_rom_clk;
  assign boot_rom_oe_n_oe = ~boot_rom_oe_n;
  assign selftest_status_oe = ~selftest_status;

  // ==========================================================================
  // retire timeout and test status pin
  logic [TO_W-1:0] to_cnt;
  logic [TO_W-1:0] next_to_cnt;
  logic [PULSE_W-1:0] pulse_cnt;
  logic [PULSE_W-1:0] next_pulse_cnt;
  logic status_base;
  logic next_status_base;
  logic next_selftest_status;
  logic next_timeout_reset;
  logic next_core_run;

  // count idle cycles in run; status follows self-test and timeout pulse
  always_comb
  begin
    next_to_cnt = to_cnt;
    next_timeout_reset = 1'b0;
    next_pulse_cnt = (pulse_cnt != '0) ? pulse_cnt - PULSE_W'(1) : pulse_cnt;
    next_status_base = status_base;
    if (state != S_RUN || instr_retired)
    begin
      next_to_cnt = '0;
    end
    else if (to_cnt == TO_LAST)
    begin
      next_to_cnt = '0;
      next_timeout_reset = 1'b1;
      next_pulse_cnt = TIMEOUT_PULSE_LOAD;
    end
    else
    begin
      next_to_cnt = to_cnt + TO_W'(1);
    end
    if (state == S_HOLD && next_state == S_BIST)
    begin
      next_status_base = 1'b1;
    end
    else if (state == S_BIST && bist_result.done)
    begin
      next_status_base = ~bist_result.pass;
    end
    if (rst_active)
    begin
      next_status_base = STATUS_RST;
      next_pulse_cnt = '0;
      next_to_cnt = '0;
      next_timeout_reset = 1'b0;
    end
    next_selftest_status = next_status_base | (next_pulse_cnt != '0);
    next_core_run = (next_state == S_RUN);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      to_cnt <= '0;
      pulse_cnt <= '0;
      status_base <= STATUS_RST;
      selftest_status <= STATUS_RST;
      timeout_reset <= 1'b0;
      core_run <= 1'b0;
    end
    else if (clk_en)
    begin
      to_cnt <= next_to_cnt;
      pulse_cnt <= next_pulse_cnt;
      status_base <= next_status_base;
      selftest_status <= next_selftest_status;
      timeout_reset <= next_timeout_reset;
      core_run <= next_core_run;
    end
  end

  // ==========================================================================
  // clock source select, wake capture and interrupt pass-through
  logic next_clock_src_bypass;
  logic next_bypass_clk_level;
  logic next_wake_captured;
  logic [IRQ_LINES-1:0] next_irq_out;

  // wake is taken only on framing clock rises; irqs go to software as levels
  always_comb
  begin
    next_clock_src_bypass = bypass_s;
    next_bypass_clk_level = bypass_s & pair_h_s & ~pair_l_s;
    next_wake_captured = frame_rise ? wake_s : wake_captured;
    next_irq_out = sync_b[NSYNC-1 -: IRQ_LINES];
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_src_bypass <= 1'b0;
      bypass_clk_level <= 1'b0;
      wake_captured <= 1'b0;
      irq_out <= '0;
    end
    else if (clk_en)
    begin
      clock_src_bypass <= next_clock_src_bypass;
      bypass_clk_level <= next_bypass_clk_level;
      wake_captured <= next_wake_captured;
      irq_out <= next_irq_out;
    end
  end
endmodule
`default_nettype wire

// >>> tb/rbtc_checker.sv
// port checker for the reset, boot and test control block
// assumes one core clock and an async active-low reset; bound into rbtc_top
`default_nettype none
module rbtc_checker
  import rbtc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = 50
)(
  input wire logic clock,
  input wire logic nrst,
  input wire logic supply_good,
  input wire logic boot_rom_clk,
  input wire logic boot_rom_oe_n,
  input wire rbtc_pkg::rbtc_rom_bit_t boot_bit,
  input wire logic bist_start,
  input wire rbtc_pkg::rbtc_bist_t bist_result,
  input wire logic instr_retired,
  input wire logic timeout_reset,
  input wire logic selftest_status,
  input wire logic core_run,
  input wire logic loop_bypass_sel,
  input wire logic clock_src_bypass,
  input wire logic framing_clock,
  input wire logic wake_captured,
  input wire logic [rbtc_pkg::IRQ_LINES-1:0] irq_in,
  input wire logic [rbtc_pkg::IRQ_LINES-1:0] irq_out
);
  logic [31:0] idle;
  logic [31:0] next_idle;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // ====================
  // run cycles since the last retire or timeout
  always_comb
  begin
    next_idle = (core_run && !instr_retired && !timeout_reset) ? idle + 32'h1 : 32'h0;
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      idle <= 32'h0;
    else
      idle <= next_idle;
  end
  // ====================
  // assertions
  // the flops take reset at the latest on the first edge that sees it, so check from the second
  AST_RESET_LOW: assert property (disable iff (1'b0) !nrst && $past(!nrst) |-> !selftest_status)
    else $error("status high in reset");
  // supply good passes two sync flops and the start decision, three edges in all
  AST_START_AFTER_GOOD: assert property (bist_start |-> $past(supply_good, 3))
    else $error("self-test started without supply good");
  AST_STATUS_AT_START: assert property (bist_start |-> selftest_status)
    else $error("status low at self-test start");
  AST_BIST_RESULT: assert property ($fell(boot_rom_oe_n) |->
    selftest_status == !$past(bist_result.pass)) else $error("status wrong after self-test");
  AST_ROM_HIGH: assert property ($rose(boot_rom_clk) && !boot_rom_oe_n |->
    ##127 boot_rom_clk ##1 (!boot_rom_clk || boot_rom_oe_n)) else $error("rom clock high time");
  AST_ROM_LOW: assert property ($fell(boot_rom_clk) |-> ##127 !boot_rom_clk ##1 boot_rom_clk)
    else $error("rom clock low time");
  AST_BIT_AT_RISE: assert property (boot_bit.valid |->
    ##[0:1] ($rose(boot_rom_clk) && !boot_rom_oe_n)) else $error("rom bit off clock rise");
  AST_PULSE_WIDTH: assert property (timeout_reset && $rose(selftest_status) |->
    ##255 selftest_status ##1 !selftest_status) else $error("timeout pulse width");
  AST_TIMEOUT_LATE: assert property (idle <= TIMEOUT_CYCLES + 32'h1)
    else $error("timeout missing");
  AST_TIMEOUT_EARLY: assert property (timeout_reset |-> idle + 32'h2 >= TIMEOUT_CYCLES)
    else $error("timeout too early");
  AST_IRQ_PASS: assert property ($past(nrst, 7) |-> irq_out == $past(irq_in, 3))
    else $error("interrupt pass-through");
  AST_BYPASS_SEL: assert property ($past(nrst, 7) |->
    clock_src_bypass == $past(loop_bypass_sel, 3)) else $error("bypass select");
  AST_WAKE_AT_FRAME: assert property ($changed(wake_captured) |->
    $past(framing_clock, 8) != $past(framing_clock, 2)) else $error("wake off framing rise");
  // main scenarios reached
  cover property (bist_start);
  cover property (boot_bit.valid);
  cover property (timeout_reset);
endmodule
bind rbtc_top rbtc_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.clock, .nrst,
  .supply_good, .boot_rom_clk, .boot_rom_oe_n, .boot_bit, .bist_start, .bist_result,
  .instr_retired, .timeout_reset, .selftest_status, .core_run, .loop_bypass_sel,
  .clock_src_bypass, .framing_clock, .wake_captured, .irq_in, .irq_out);
`default_nettype wire

// >>> tb/rbtc_board_model.sv
// board and serial boot rom model for the reset, boot and test control block
// assumes the rom clock and enable levels of rbtc_top and a 4-bit rom image
`default_nettype none
module rbtc_board_model (
  input wire logic clock,
  input wire logic boot_rom_clk,
  input wire logic boot_rom_oe_n,
  input wire logic [3:0] rom_word,
  input wire logic wake_set,
  output logic boot_rom_din,
  output logic framing_clock,
  output logic wake_request
);
  // framing clock and wake line start low
  initial
  begin
    framing_clock = 1'b0;
    wake_request = 1'b0;
  end
  logic [1:0] idx;
  logic last = 1'b0;
  logic [3:0] fdiv = 4'h0;
  // rom steps to its next bit on each clock rise, restarts when deselected
  always @(posedge boot_rom_clk or posedge boot_rom_oe_n)
    idx <= boot_rom_oe_n ? 2'h0 : idx + 2'h1;
  always @(negedge clock)
    if (!boot_rom_oe_n) last <= rom_word[idx];
  // a released data line shows the inverse of the last bit
  assign boot_rom_din = boot_rom_oe_n ? ~last : rom_word[idx];
  // free framing clock, ten core cycles per half; wake moves at its rise
  always @(negedge clock)
  begin
    fdiv <= (fdiv == 4'h9) ? 4'h0 : fdiv + 4'h1;
    if (fdiv == 4'h9) framing_clock <= ~framing_clock;
    if (fdiv == 4'h9 && !framing_clock) wake_request <= wake_set;
  end
endmodule
`default_nettype wire

// >>> tb/rbtc_top_tb.sv
// self-checking bench for rbtc_top with the board and rom model
// assumes a 20 MHz core clock, short timeout of 50 and four boot bits
`default_nettype none
module rbtc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rbtc_pkg::*;
  localparam logic [3:0] ROM_WORD = 4'ha;
  logic clock, nrst, supply_good, boot_rom_din, boot_rom_clk, boot_rom_oe_n, boot_done;
  logic bist_start, instr_retired, timeout_reset, selftest_status, core_run, wake_set;
  logic loop_bypass_sel, clock_src_bypass, bypass_clk_level, framing_clock, wake_request;
  logic wake_captured, hit;
  logic rom_clk_oe, rom_oe_oe, stat_oe;
  logic [1:0] input_clock_pair;
  logic [5:0] irq_in, irq_out;
  rbtc_rom_bit_t boot_bit;
  rbtc_bist_t bist_result;
  int err_total, checked, cyc, n, t0;
  rbtc_top #(.TIMEOUT_CYCLES(50), .BOOT_BITS(4)) DUT (.clock, .nrst, .clk_en(1'b1),
    .supply_good, .boot_rom_din, .boot_rom_clk, .boot_rom_clk_oe(rom_clk_oe), .boot_rom_oe_n,
    .boot_rom_oe_n_oe(rom_oe_oe), .boot_bit, .boot_done, .bist_start, .bist_result,
    .instr_retired, .timeout_reset, .selftest_status, .selftest_status_oe(stat_oe), .core_run,
    .loop_bypass_sel,
    .input_clock_pair, .clock_src_bypass, .bypass_clk_level, .framing_clock,
    .wake_request, .wake_captured, .irq_in, .irq_out);
  rbtc_board_model board (.clock, .boot_rom_clk, .boot_rom_oe_n, .rom_word(ROM_WORD),
    .wake_set, .boot_rom_din, .framing_clock, .wake_request);
  // ====================
  // clock and run-time ceiling
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic wait_start();
    for (n = 0; n < 20 && bist_start !== 1'b1; n++) @(negedge clock);
    chk("bist start", bist_start, 1);
    chk("status at start", selftest_status, 1);
  endtask
  task automatic t_bist(input logic pass);
    bist_result = {1'b1, pass};
    @(negedge clock);
    bist_result.done = 1'b0;
    @(negedge clock);
    chk("status after bist", selftest_status, !pass);
    chk("rom enable in boot", boot_rom_oe_n, 0);
    chk("rom enable pin driven", rom_oe_oe, 1);
    $display("bist %0d done", pass);
  endtask
  task automatic t_boot();
    for (int i = 0; i < 4; i++)
    begin
      for (n = 0; n < 300 && boot_bit.valid !== 1'b1; n++) @(negedge clock);
      chk("rom bit", boot_bit.data, ROM_WORD[i]);
      if (i > 0) chk("rom bit gap", 16'(cyc - t0), 256);
      t0 = cyc;
      @(negedge clock);
    end
    for (n = 0; n < 300 && boot_done !== 1'b1; n++) @(negedge clock);
    chk("run after boot", core_run, 1);
    chk("rom released", boot_rom_oe_n, 1);
    chk("boot done flag", boot_done, 1);
    chk("rom clock pin released", rom_clk_oe, 0);
    $display("boot done");
  endtask
  task automatic t_timeout();
    hit = 1'b0;
    for (n = 0; n < 200; n++)
    begin
      instr_retired = (n % 10 == 0);
      @(negedge clock);
      if (timeout_reset === 1'b1) hit = 1'b1;
    end
    chk("no timeout while retiring", hit, 0);
    instr_retired = 1'b0;
    for (n = 0; n < 60 && timeout_reset !== 1'b1; n++) @(negedge clock);
    chk("timeout fired", timeout_reset, 1);
    instr_retired = 1'b1;
    for (n = 0; n < 300 && selftest_status === 1'b1; n++) @(negedge clock);
    chk("timeout pulse width", 16'(n), 256);
    $display("timeout done");
  endtask
  task automatic t_misc();
    for (int k = 0; k < 6; k++)
    begin
      irq_in = 6'h01 << k;
      repeat (4) @(negedge clock);
      chk("irq pass", irq_out, irq_in);
    end
    loop_bypass_sel = 1'b1;
    input_clock_pair = 2'h2;
    repeat (4) @(negedge clock);
    chk("bypass select", clock_src_bypass, 1);
    chk("bypass level high", bypass_clk_level, 1);
    input_clock_pair = 2'h1;
    repeat (4) @(negedge clock);
    chk("bypass level low", bypass_clk_level, 0);
    loop_bypass_sel = 1'b0;
    wake_set = 1'b1;
    repeat (30) @(negedge clock);
    chk("wake captured", wake_captured, 1);
    wake_set = 1'b0;
    repeat (30) @(negedge clock);
    chk("wake cleared", wake_captured, 0);
    $display("misc done");
  endtask
  // ====================
  // main sequence: power-up, pass run, then reset into a failing self-test
  initial
  begin
    {nrst, supply_good, instr_retired, loop_bypass_sel, wake_set} = 5'h0;
    {input_clock_pair, irq_in, bist_result} = 10'h0;
    err_total = 0;
    checked = 0;
    t0 = 0;
    repeat (10) @(negedge clock);
    chk("status in reset", selftest_status, 0);
    chk("status pin pulled low in reset", stat_oe, 1);
    chk("rom idle in reset", boot_rom_oe_n, 1);
    supply_good = 1'b1;
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    wait_start();
    t_bist(1'b1);
    t_boot();
    t_timeout();
    t_misc();
    nrst = 1'b0;
    repeat (10) @(negedge clock);
    chk("status in second reset", selftest_status, 0);
    nrst = 1'b1;
    wait_start();
    t_bist(1'b0);
    summarize();
  end
endmodule
`default_nettype wire
